// [include/hub_cfg_pkg.sv]
// shared constants, types and register map of the hub configuration loader
package hub_cfg_pkg;
  // register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_UP_BOOST = 8'h00;
  localparam logic [7:0] OFS_DN_BOOST = 8'h04;
  localparam logic [7:0] OFS_STATUS_CMD = 8'h08;
  localparam logic [7:0] OFS_LOAD_STAT = 8'h0c;
  localparam logic [7:0] OFS_MAC_LO = 8'h10;
  localparam logic [7:0] OFS_MAC_HI = 8'h14;
  localparam logic [7:0] OFS_POLL = 8'h18;
  localparam logic [7:0] OFS_RELOAD = 8'h1c;
  // field positions and writable masks
  localparam int UP_CODE_LSB = 0;
  localparam int P2_CODE_LSB = 2;
  localparam int P3_CODE_LSB = 4;
  localparam int ST_ATTACH_BIT = 0;
  localparam int ST_SOFTWARE_RESET_BIT = 1;
  localparam int LS_BUSY_BIT = 0;
  localparam int LS_SIG_BIT = 1;
  localparam int RL_ETH_BIT = 0;
  localparam logic [7:0] UP_MASK = 8'h03;
  localparam logic [7:0] DN_MASK = 8'h3c;
  // reset values
  localparam logic [7:0] DEF_BOOST = 8'h00;
  localparam logic [47:0] DEF_MAC = 48'hffff_ffff_ffff;
  localparam logic [7:0] DEF_FS_POLL = 8'h01;
  localparam logic [7:0] DEF_HS_POLL = 8'h04;
  // eeprom layout
  localparam logic [7:0] EE_SIGNATURE = 8'ha5;
  localparam logic [7:0] EE_SIG_ADDR = 8'h00;
  localparam logic [7:0] EE_MAC_FIRST = 8'h01;
  localparam logic [7:0] EE_MAC_LAST = 8'h06;
  localparam logic [7:0] EE_FS_ADDR = 8'h07;
  localparam logic [7:0] EE_HS_ADDR = 8'h08;
  localparam logic [7:0] EE_UPB_ADDR = 8'hf0;
  localparam logic [7:0] EE_DNB_ADDR = 8'hf1;
  // drive boost step per code increment, in percent
  localparam logic [3:0] BOOST_STEP_PCT = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {LOAD_MAC = 2'b01, LOAD_ETH = 2'b10, LOAD_FULL = 2'b11} load_kind_e;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SIG = 2'b01, ST_DATA = 2'b11} ld_state_e;

  typedef struct packed {
    logic [47:0] mac;
    logic [7:0] hs_poll;
    logic [7:0] fs_poll;
  } eth_cfg_s;

  localparam eth_cfg_s DEF_ETH = '{mac: DEF_MAC, hs_poll: DEF_HS_POLL, fs_poll: DEF_FS_POLL};
endpackage : hub_cfg_pkg

// [core/hub_config_eeprom_autoload.sv]
// hub configuration registers with eeprom auto-load, reached over AXI4-Lite
//
// Notes on behaviour
// - upstream boost code in bits 1:0 only
// - port three boost code in bits 5:4
// - port two boost code in bits 3:2
// - codes give +0, +4, +8, +12 percent
// - soft reset bit restores config register defaults; the code restores only the boost registers, attach keeps its value
// - soft reset bit clears itself, reads zero; a read accepted in the first cycle of the write response returns one
// - attach bit signals attach toward upstream host
// - attach set blocks writes to config memory
// - attach set once, cleared only by resets
// - attach zero means configuration state, resets one
// - eeprom byte zero must hold a5 signature
// - bad signature means no auto-load at all
// - without signature use ones mac, polls 01/04
// - usb, power-on, pin and soft resets trigger load
// - power-on or pin reset loads hub and ethernet
// - usb bus reset reloads mac address only
// - soft reset or reload loads ethernet only
// - mac address from eeprom bytes 01h-06h
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module hub_config_eeprom_autoload #(
  parameter logic ATTACH_RESET = 1'b1
) (
  input wire logic REF_CLK, // 125 MHz device clock
  input wire logic RESET, // power-on reset, synchronous
  input wire logic EXTERNAL_RESET_PIN_N, // reset pin, asynchronous
  input wire logic USB_BUS_RESET, // one-cycle usb bus reset event
  input wire logic [7:0] AWADDR, // write address
  input wire logic AWVALID, // write address valid
  output logic AWREADY, // write address ready
  input wire logic [31:0] WDATA, // write data
  input wire logic [3:0] WSTRB, // write strobes
  input wire logic WVALID, // write data valid
  output logic WREADY, // write data ready
  output logic [1:0] BRESP, // write response
  output logic BVALID, // write response valid
  input wire logic BREADY, // write response ready
  input wire logic [7:0] ARADDR, // read address
  input wire logic ARVALID, // read address valid
  output logic ARREADY, // read address ready
  output logic [31:0] RDATA, // read data
  output logic [1:0] RRESP, // read response
  output logic RVALID, // read data valid
  input wire logic RREADY, // read data ready
  output logic EE_RD_REQ, // eeprom byte read request
  output logic [7:0] EE_RD_ADDR, // eeprom byte address
  input wire logic EE_RD_ACK, // eeprom byte ready, one cycle
  input wire logic [7:0] EE_RD_DATA, // eeprom byte value
  output logic USB_ATTACH, // attach toward upstream host
  output logic [3:0] UPSTREAM_BOOST_PCT, // upstream boost percent
  output logic [3:0] PORT_TWO_BOOST_PCT, // port two boost percent
  output logic [3:0] PORT_THREE_BOOST_PCT, // port three boost percent
  output hub_cfg_pkg::eth_cfg_s ETH_CFG, // loaded ethernet settings
  output logic LOAD_BUSY // auto-load in progress
);
  import hub_cfg_pkg::*;

  // code to percent: each step adds four percent
  function automatic logic [3:0] boost_pct(input logic [1:0] code);
    boost_pct = 4'(code * BOOST_STEP_PCT);
  endfunction : boost_pct

  // reset pin synchroniser
  logic [1:0] pin_sync_ff;
  logic [1:0] nxt_pin_sync;
  logic pin_low;

  always_comb begin
    nxt_pin_sync = {pin_sync_ff[0], EXTERNAL_RESET_PIN_N};
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pin_sync_ff <= 2'b11;
    end else begin
      pin_sync_ff <= nxt_pin_sync;
    end
  end

  assign pin_low = !pin_sync_ff[1];

  // bus slave state
  logic awready_ff, wready_ff, aw_held_ff, w_held_ff, bvalid_ff;
  logic arready_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic nxt_awready, nxt_wready, nxt_aw_held, nxt_w_held, nxt_bvalid;
  logic nxt_arready, nxt_rvalid;
  logic [7:0] nxt_awaddr;
  logic [31:0] nxt_wdata, nxt_rdata;
  logic [3:0] nxt_wstrb;
  logic [1:0] nxt_bresp, nxt_rresp;
  logic wr_fire, wr_lane0;

  // config register state
  logic [7:0] up_ff, dn_ff, nxt_up, nxt_dn;
  logic attach_ff, software_reset_ff, nxt_attach, nxt_software_reset;
  logic [3:0] up_pct_ff, p2_pct_ff, p3_pct_ff;
  logic reload_req;

  // loader state
  ld_state_e state_ff, nxt_state;
  load_kind_e kind_ff, nxt_kind;
  logic [2:0] pend_ff, nxt_pend;
  logic [7:0] addr_ff, nxt_addr;
  logic req_ff, nxt_req, sig_ok_ff, nxt_sig_ok, busy_ff;
  eth_cfg_s eth_ff, nxt_eth;
  logic ack, ld_up_we, ld_dn_we, last_byte;

  // write side: address and data are taken independently, response after both
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_lane0 = wr_fire && wstrb_ff[0];

  always_comb begin
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_aw_held = aw_held_ff;
    nxt_w_held = w_held_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (AWVALID && awready_ff) begin
      nxt_aw_held = 1'b1;
      nxt_awaddr = AWADDR;
    end
    if (WVALID && wready_ff) begin
      nxt_w_held = 1'b1;
      nxt_wdata = WDATA;
      nxt_wstrb = WSTRB;
    end
    if (wr_fire) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      case (awaddr_ff)
        OFS_UP_BOOST, OFS_DN_BOOST: nxt_bresp = attach_ff ? RESP_SLVERR : RESP_OKAY;
        OFS_STATUS_CMD, OFS_LOAD_STAT, OFS_MAC_LO, OFS_MAC_HI, OFS_POLL, OFS_RELOAD: nxt_bresp = RESP_OKAY;
        default: nxt_bresp = RESP_SLVERR;
      endcase
    end else if (bvalid_ff && BREADY) begin
      nxt_bvalid = 1'b0;
    end
    // one write in flight: stay closed until the response is taken
    nxt_awready = !nxt_aw_held && !nxt_bvalid;
    nxt_wready = !nxt_w_held && !nxt_bvalid;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
    end
  end

  // read side: data one cycle after the address is taken
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (ARVALID && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      nxt_rdata = 32'h0000_0000;
      case (ARADDR)
        OFS_UP_BOOST: nxt_rdata[7:0] = up_ff;
        OFS_DN_BOOST: nxt_rdata[7:0] = dn_ff;
        OFS_STATUS_CMD: nxt_rdata[7:0] = {6'h00, software_reset_ff, attach_ff};
        OFS_LOAD_STAT: nxt_rdata[7:0] = {6'h00, sig_ok_ff, busy_ff};
        OFS_MAC_LO: nxt_rdata = eth_ff.mac[31:0];
        OFS_MAC_HI: nxt_rdata[15:0] = eth_ff.mac[47:32];
        OFS_POLL: nxt_rdata[15:0] = {eth_ff.hs_poll, eth_ff.fs_poll};
        OFS_RELOAD: nxt_rdata = 32'h0000_0000;
        default: nxt_rresp = RESP_SLVERR;
      endcase
    end else if (rvalid_ff && RREADY) begin
      nxt_rvalid = 1'b0;
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else begin
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign reload_req = wr_lane0 && (awaddr_ff == OFS_RELOAD) && wdata_ff[RL_ETH_BIT];

  // config registers; loader and resets take priority over bus writes
  always_comb begin
    nxt_up = up_ff;
    nxt_dn = dn_ff;
    nxt_attach = attach_ff;
    nxt_software_reset = 1'b0;
    if (wr_lane0 && !attach_ff) begin
      if (awaddr_ff == OFS_UP_BOOST) begin
        nxt_up = wdata_ff[7:0] & UP_MASK;
      end
      if (awaddr_ff == OFS_DN_BOOST) begin
        nxt_dn = wdata_ff[7:0] & DN_MASK;
      end
    end
    if (wr_lane0 && (awaddr_ff == OFS_STATUS_CMD)) begin
      if (wdata_ff[ST_ATTACH_BIT]) begin
        nxt_attach = 1'b1;
      end
      nxt_software_reset = wdata_ff[ST_SOFTWARE_RESET_BIT];
    end
    if (ld_up_we) begin
      nxt_up = EE_RD_DATA & UP_MASK;
    end
    if (ld_dn_we) begin
      nxt_dn = EE_RD_DATA & DN_MASK;
    end
    // soft reset leaves attach alone: only the pin or power-on reloads it with ATTACH_RESET
    if (software_reset_ff || pin_low) begin
      nxt_up = DEF_BOOST;
      nxt_dn = DEF_BOOST;
    end
    if (pin_low) begin
      nxt_attach = ATTACH_RESET;
      nxt_software_reset = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      up_ff <= DEF_BOOST;
      dn_ff <= DEF_BOOST;
      attach_ff <= ATTACH_RESET;
      software_reset_ff <= 1'b0;
      up_pct_ff <= 4'h0;
      p2_pct_ff <= 4'h0;
      p3_pct_ff <= 4'h0;
    end else begin
      up_ff <= nxt_up;
      dn_ff <= nxt_dn;
      attach_ff <= nxt_attach;
      software_reset_ff <= nxt_software_reset;
      up_pct_ff <= boost_pct(nxt_up[UP_CODE_LSB +: 2]);
      p2_pct_ff <= boost_pct(nxt_dn[P2_CODE_LSB +: 2]);
      p3_pct_ff <= boost_pct(nxt_dn[P3_CODE_LSB +: 2]);
    end
  end

  // loader strobes into the config group
  assign ack = EE_RD_ACK && req_ff;
  assign ld_up_we = (state_ff == ST_DATA) && ack && (addr_ff == EE_UPB_ADDR);
  assign ld_dn_we = (state_ff == ST_DATA) && ack && (addr_ff == EE_DNB_ADDR);
  assign last_byte = ((kind_ff == LOAD_MAC) && (addr_ff == EE_MAC_LAST))
                  || ((kind_ff == LOAD_ETH) && (addr_ff == EE_HS_ADDR))
                  || ((kind_ff == LOAD_FULL) && (addr_ff == EE_DNB_ADDR));

  // loader: pending triggers {full, eth, mac}; wider loads cover narrower ones
  always_comb begin
    nxt_pend = pend_ff | {pin_low, software_reset_ff || reload_req, USB_BUS_RESET};
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_addr = addr_ff;
    nxt_sig_ok = sig_ok_ff;
    nxt_eth = eth_ff;
    case (state_ff)
      ST_IDLE: begin
        if (nxt_pend != 3'b000) begin
          nxt_state = ST_SIG;
          nxt_addr = EE_SIG_ADDR;
          if (nxt_pend[2]) begin
            nxt_kind = LOAD_FULL;
            nxt_pend = 3'b000;
          end else if (nxt_pend[1]) begin
            nxt_kind = LOAD_ETH;
            nxt_pend = 3'b000;
          end else begin
            nxt_kind = LOAD_MAC;
            nxt_pend[0] = 1'b0;
          end
        end
      end
      ST_SIG: begin
        if (ack) begin
          if (EE_RD_DATA == EE_SIGNATURE) begin
            nxt_sig_ok = 1'b1;
            nxt_addr = EE_MAC_FIRST;
            nxt_state = ST_DATA;
          end else begin
            nxt_sig_ok = 1'b0;
            nxt_state = ST_IDLE;
            nxt_eth.mac = DEF_MAC;
            if (kind_ff != LOAD_MAC) begin
              nxt_eth.fs_poll = DEF_FS_POLL;
              nxt_eth.hs_poll = DEF_HS_POLL;
            end
          end
        end
      end
      ST_DATA: begin
        if (ack) begin
          for (int k = 0; k < 6; k++) begin
            if (addr_ff == 8'(EE_MAC_FIRST + 8'(k))) begin
              nxt_eth.mac[8 * (5 - k) +: 8] = EE_RD_DATA;
            end
          end
          if (addr_ff == EE_FS_ADDR) begin
            nxt_eth.fs_poll = EE_RD_DATA;
          end
          if (addr_ff == EE_HS_ADDR) begin
            nxt_eth.hs_poll = EE_RD_DATA;
          end
          if (last_byte) begin
            nxt_state = ST_IDLE;
          end else if (addr_ff == EE_HS_ADDR) begin
            nxt_addr = EE_UPB_ADDR; // hub part of a full load
          end else if (addr_ff == EE_UPB_ADDR) begin
            nxt_addr = EE_DNB_ADDR;
          end else begin
            nxt_addr = 8'(addr_ff + 8'h01);
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    // pin held low aborts any load; a full load follows the release
    // the idle branch may have consumed the trigger, so keep a full load queued until release
    if (pin_low) begin
      nxt_state = ST_IDLE;
      nxt_pend = 3'b100;
    end
    // request drops for a cycle after each byte so the address may change
    nxt_req = (nxt_state != ST_IDLE) && !ack;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state_ff <= ST_IDLE;
      kind_ff <= LOAD_FULL;
      pend_ff <= 3'b100;
      addr_ff <= EE_SIG_ADDR;
      req_ff <= 1'b0;
      sig_ok_ff <= 1'b0;
      busy_ff <= 1'b0;
      eth_ff <= DEF_ETH;
    end else begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      pend_ff <= nxt_pend;
      addr_ff <= nxt_addr;
      req_ff <= nxt_req;
      sig_ok_ff <= nxt_sig_ok;
      busy_ff <= (nxt_state != ST_IDLE);
      eth_ff <= nxt_eth;
    end
  end

  // outputs, all from flip-flops
  assign AWREADY = awready_ff;
  assign WREADY = wready_ff;
  assign BVALID = bvalid_ff;
  assign BRESP = bresp_ff;
  assign ARREADY = arready_ff;
  assign RVALID = rvalid_ff;
  assign RDATA = rdata_ff;
  assign RRESP = rresp_ff;
  assign EE_RD_REQ = req_ff;
  assign EE_RD_ADDR = addr_ff;
  assign USB_ATTACH = attach_ff;
  assign UPSTREAM_BOOST_PCT = up_pct_ff;
  assign PORT_TWO_BOOST_PCT = p2_pct_ff;
  assign PORT_THREE_BOOST_PCT = p3_pct_ff;
  assign ETH_CFG = eth_ff;
  assign LOAD_BUSY = busy_ff;
endmodule : hub_config_eeprom_autoload

// [verif/hub_cfg_asserts.sv]
// port-level checker for the hub configuration loader
`timescale 1ns/1ps
module hub_cfg_asserts #(
  parameter logic ATTACH_RESET = 1'b1
) (
  input wire logic REF_CLK, // clock
  input wire logic RESET, // power-on reset
  input wire logic EXTERNAL_RESET_PIN_N, // reset pin
  input wire logic [7:0] AWADDR, // write address
  input wire logic AWVALID, // aw valid
  input wire logic AWREADY, // aw ready
  input wire logic [31:0] WDATA, // write data
  input wire logic [3:0] WSTRB, // strobes
  input wire logic WVALID, // w valid
  input wire logic WREADY, // w ready
  input wire logic [1:0] BRESP, // write response
  input wire logic BVALID, // b valid
  input wire logic [7:0] ARADDR, // read address
  input wire logic ARVALID, // ar valid
  input wire logic ARREADY, // ar ready
  input wire logic [31:0] RDATA, // read data
  input wire logic RVALID, // r valid
  input wire logic EE_RD_REQ, // eeprom request
  input wire logic [7:0] EE_RD_ADDR, // eeprom address
  input wire logic EE_RD_ACK, // eeprom answer
  input wire logic [7:0] EE_RD_DATA, // eeprom byte
  input wire logic USB_ATTACH, // attach level
  input wire logic [3:0] UPSTREAM_BOOST_PCT, // upstream percent
  input wire logic [3:0] PORT_TWO_BOOST_PCT, // port two percent
  input wire logic [3:0] PORT_THREE_BOOST_PCT, // port three percent
  input wire logic LOAD_BUSY // loader busy
);
  import hub_cfg_pkg::*;
  logic [7:0] aw_ff;
  logic [7:0] ar_ff;
  logic [8:0] w_ff;
  // remember the last accepted addresses and byte lane, so answers can be tied to their request
  always_ff @(posedge REF_CLK) begin
    if (AWVALID && AWREADY) aw_ff <= AWADDR;
    if (WVALID && WREADY) w_ff <= {WSTRB[0], WDATA[7:0]};
    if (ARVALID && ARREADY) ar_ff <= ARADDR;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // three low samples of the raw pin are enough for the pin reset to land
  pin_attach_a: assert property (!EXTERNAL_RESET_PIN_N [*3] |=> USB_ATTACH == ATTACH_RESET)
    else $error("attach not restored by pin reset");
  attach_once_a: assert property (ATTACH_RESET |-> !$fell(USB_ATTACH))
    else $error("attach cleared after being set");
  up_pct_a: assert property (RVALID && ar_ff == OFS_UP_BOOST |->
    UPSTREAM_BOOST_PCT == {RDATA[1:0], 2'b00} && RDATA[31:2] == '0)
    else $error("upstream percent or reserved bits wrong");
  dn_pct_a: assert property (RVALID && ar_ff == OFS_DN_BOOST |-> PORT_TWO_BOOST_PCT == {RDATA[3:2], 2'b00}
    && PORT_THREE_BOOST_PCT == {RDATA[5:4], 2'b00} && RDATA[31:6] == '0 && RDATA[1:0] == 2'b00)
    else $error("downstream percent or reserved bits wrong");
  status_rd_a: assert property (RVALID && ar_ff == OFS_STATUS_CMD |->
    RDATA[0] == USB_ATTACH && RDATA[31:2] == '0)
    else $error("status read disagrees with attach");
  prot_wr_a: assert property ($rose(BVALID) && USB_ATTACH && w_ff[8] &&
    (aw_ff == OFS_UP_BOOST || aw_ff == OFS_DN_BOOST) |-> BRESP == RESP_SLVERR)
    else $error("protected write not refused");
  software_reset_clr_a: assert property ($rose(BVALID) && aw_ff == OFS_STATUS_CMD && w_ff[8] && w_ff[1] |=>
    UPSTREAM_BOOST_PCT == 4'h0 && PORT_TWO_BOOST_PCT == 4'h0 && PORT_THREE_BOOST_PCT == 4'h0)
    else $error("soft reset left boost set");
  sig_first_a: assert property ($rose(LOAD_BUSY) |-> EE_RD_REQ && EE_RD_ADDR == EE_SIG_ADDR)
    else $error("load did not start at signature byte");
  bad_sig_a: assert property (EE_RD_REQ && EE_RD_ACK && EE_RD_ADDR == EE_SIG_ADDR &&
    EE_RD_DATA != EE_SIGNATURE |=> !EE_RD_REQ && !LOAD_BUSY ##1 !EE_RD_REQ)
    else $error("load went on after bad signature");
endmodule : hub_cfg_asserts

bind hub_config_eeprom_autoload hub_cfg_asserts #(.ATTACH_RESET(ATTACH_RESET)) chk (.REF_CLK, .RESET,
  .EXTERNAL_RESET_PIN_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID,
  .ARADDR, .ARVALID, .ARREADY, .RDATA, .RVALID, .EE_RD_REQ, .EE_RD_ADDR, .EE_RD_ACK, .EE_RD_DATA,
  .USB_ATTACH, .UPSTREAM_BOOST_PCT, .PORT_TWO_BOOST_PCT, .PORT_THREE_BOOST_PCT, .LOAD_BUSY);

// [verif/hub_ee_model.sv]
// behavioural serial configuration eeprom, byte read port
`timescale 1ns/1ps
module hub_ee_model (
  input wire logic REF_CLK, // clock
  input wire logic EE_RD_REQ, // byte request
  input wire logic [7:0] EE_RD_ADDR, // byte address
  output logic EE_RD_ACK, // one-cycle answer
  output logic [7:0] EE_RD_DATA // byte value
);
  logic [7:0] mem [256]; // contents, filled by the bench
  int lat = 0; // answer delay, set by the bench
  int cnt = 0;
  initial begin
    EE_RD_ACK = 1'b0;
    EE_RD_DATA = 8'h00;
  end
  // data toggles outside the answer cycle so a late sample never sees a stale byte
  always @(posedge REF_CLK) begin
    EE_RD_ACK <= 1'b0;
    EE_RD_DATA <= ~EE_RD_DATA;
    if (EE_RD_REQ && !EE_RD_ACK && cnt >= lat) begin
      EE_RD_ACK <= 1'b1;
      EE_RD_DATA <= mem[EE_RD_ADDR];
      cnt <= 0;
    end else begin
      cnt <= EE_RD_REQ ? cnt + 1 : 0;
    end
  end
endmodule : hub_ee_model

// [verif/hub_config_eeprom_autoload_tb_top.sv]
// self-checking bench for the hub configuration loader
`timescale 1ns/1ps
module hub_config_eeprom_autoload_tb_top;
  import hub_cfg_pkg::*;
  logic REF_CLK = 1'b0;
  logic RESET = 1'b1;
  logic EXTERNAL_RESET_PIN_N = 1'b1;
  logic USB_BUS_RESET = 1'b0;
  logic [7:0] AWADDR = 8'h00;
  logic [7:0] ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'h0;
  logic AWVALID = 1'b0;
  logic WVALID = 1'b0;
  logic BREADY = 1'b0;
  logic ARVALID = 1'b0;
  logic RREADY = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, EE_RD_REQ, EE_RD_ACK, USB_ATTACH, LOAD_BUSY;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA;
  logic [7:0] EE_RD_ADDR, EE_RD_DATA;
  logic [3:0] UPSTREAM_BOOST_PCT, PORT_TWO_BOOST_PCT, PORT_THREE_BOOST_PCT;
  eth_cfg_s ETH_CFG;
  int error_cnt = 0;
  int n_checks = 0;
  always #4 REF_CLK = ~REF_CLK;
  hub_config_eeprom_autoload uut (.REF_CLK, .RESET, .EXTERNAL_RESET_PIN_N, .USB_BUS_RESET, .AWADDR, .AWVALID,
    .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
    .RRESP, .RVALID, .RREADY, .EE_RD_REQ, .EE_RD_ADDR, .EE_RD_ACK, .EE_RD_DATA, .USB_ATTACH,
    .UPSTREAM_BOOST_PCT, .PORT_TWO_BOOST_PCT, .PORT_THREE_BOOST_PCT, .ETH_CFG, .LOAD_BUSY);
  hub_ee_model ee (.REF_CLK, .EE_RD_REQ, .EE_RD_ADDR, .EE_RD_ACK, .EE_RD_DATA);

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge REF_CLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'h1;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge REF_CLK);
      n++;
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID && n < 50);
    BREADY <= 1'b0;
    chk("bvalid", 1, BVALID);
    chk("bresp", er, BRESP);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge REF_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge REF_CLK);
      n++;
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID && n < 50);
    RREADY <= 1'b0;
    chk("rvalid", 1, RVALID);
    chk("rdata", ed, RDATA);
    chk("rresp", er, RRESP);
  endtask : rd

  // a load starts a few cycles after its trigger, so give it time to show busy
  task automatic idle();
    int n;
    n = 0;
    repeat (5) @(posedge REF_CLK);
    while (LOAD_BUSY !== 1'b0 && n < 2000) begin
      @(posedge REF_CLK);
      n++;
    end
    chk("load_busy", 0, LOAD_BUSY);
  endtask : idle

  task automatic fill(input logic [7:0] sig, input logic [47:0] mac, input logic [7:0] fs, hs, up, dn);
    ee.mem[EE_SIG_ADDR] = sig;
    for (int i = 0; i < 6; i++) ee.mem[EE_MAC_FIRST + i] = mac[47 - 8 * i -: 8];
    ee.mem[EE_FS_ADDR] = fs;
    ee.mem[EE_HS_ADDR] = hs;
    ee.mem[EE_UPB_ADDR] = up;
    ee.mem[EE_DNB_ADDR] = dn;
  endtask : fill

  initial begin
    repeat (20000) @(posedge REF_CLK);
    error_cnt++;
    close_out();
  end

  initial begin
    fill(8'ha5, 48'h1234_5678_9abc, 8'h02, 8'h08, 8'hfe, 8'hd9);
    repeat (4) @(posedge REF_CLK);
    RESET <= 1'b0;
    idle();
    rd(OFS_UP_BOOST, 32'h02, RESP_OKAY);
    rd(OFS_DN_BOOST, 32'h18, RESP_OKAY);
    chk("boost_pct", 12'h884, {UPSTREAM_BOOST_PCT, PORT_TWO_BOOST_PCT, PORT_THREE_BOOST_PCT});
    rd(OFS_STATUS_CMD, 32'h01, RESP_OKAY);
    chk("usb_attach", 1, USB_ATTACH);
    chk("eth_cfg", {48'h1234_5678_9abc, 8'h08, 8'h02}, ETH_CFG);
    rd(OFS_MAC_HI, 32'h1234, RESP_OKAY);
    rd(OFS_LOAD_STAT, 32'h02, RESP_OKAY);
    wr(OFS_UP_BOOST, 32'h03, RESP_SLVERR);
    rd(OFS_UP_BOOST, 32'h02, RESP_OKAY);
    wr(OFS_STATUS_CMD, 32'h00, RESP_OKAY);
    rd(OFS_STATUS_CMD, 32'h01, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    // usb bus reset with a slow eeprom: only the mac may change
    fill(8'ha5, 48'ha1a2_a3a4_a5a6, 8'h11, 8'h22, 8'h01, 8'h00);
    ee.lat = 3;
    USB_BUS_RESET <= 1'b1;
    @(posedge REF_CLK);
    USB_BUS_RESET <= 1'b0;
    idle();
    chk("eth_cfg", {48'ha1a2_a3a4_a5a6, 8'h08, 8'h02}, ETH_CFG);
    rd(OFS_UP_BOOST, 32'h02, RESP_OKAY);
    wr(OFS_STATUS_CMD, 32'h02, RESP_OKAY);
    rd(OFS_STATUS_CMD, 32'h01, RESP_OKAY);
    idle();
    rd(OFS_DN_BOOST, 32'h00, RESP_OKAY);
    chk("eth_cfg", {48'ha1a2_a3a4_a5a6, 8'h22, 8'h11}, ETH_CFG);
    // unprogrammed eeprom seen through the reload command
    ee.mem[EE_SIG_ADDR] = 8'h5a;
    wr(OFS_RELOAD, 32'h01, RESP_OKAY);
    idle();
    chk("eth_cfg", {48'hffff_ffff_ffff, 8'h04, 8'h01}, ETH_CFG);
    rd(OFS_LOAD_STAT, 32'h00, RESP_OKAY);
    ee.mem[EE_SIG_ADDR] = 8'ha5;
    ee.lat = 0;
    EXTERNAL_RESET_PIN_N <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    EXTERNAL_RESET_PIN_N <= 1'b1;
    idle();
    rd(OFS_UP_BOOST, 32'h01, RESP_OKAY);
    chk("boost_pct", 12'h400, {UPSTREAM_BOOST_PCT, PORT_TWO_BOOST_PCT, PORT_THREE_BOOST_PCT});
    chk("eth_cfg", {48'ha1a2_a3a4_a5a6, 8'h22, 8'h11}, ETH_CFG);
    chk("usb_attach", 1, USB_ATTACH);
    close_out();
  end
endmodule : hub_config_eeprom_autoload_tb_top
